// ===== common/dio_pkg.sv
// dio_pkg: constants of the identification and error-reporting register bank.
// assumes: one 40 MHz clock; registers reached over AXI4-Lite with 32-bit data.
`default_nettype none
package dio_pkg;
   // ==========================================================================
   // bus widths and responses
   localparam int          ADDR_W        = 16;
   localparam int          DATA_W        = 32;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [1:0]  RESP_DECERR   = 2'h3;

   // ==========================================================================
   // object indices and their byte addresses (four bytes per index)
   localparam logic [ADDR_W-1:0] IDX_DEV_TYPE  = 16'h1000;
   localparam logic [ADDR_W-1:0] IDX_ERR_SUM   = 16'h1001;
   localparam logic [ADDR_W-1:0] IDX_ERR_HIST  = 16'h1003;
   localparam logic [ADDR_W-1:0] ADDR_DEV_TYPE = ADDR_W'({IDX_DEV_TYPE, 2'h0});
   localparam logic [ADDR_W-1:0] ADDR_ERR_SUM  = ADDR_W'({IDX_ERR_SUM, 2'h0});
   localparam logic [ADDR_W-1:0] ADDR_ERR_HIST = ADDR_W'({IDX_ERR_HIST, 2'h0});
   // history sub-entry k sits at HIST_SUB_BASE + 4*k, k = 0..8
   localparam logic [ADDR_W-1:0] HIST_SUB_BASE = 16'h6000;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 16'h7000;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 16'h7004;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 16'h7008;

   // ==========================================================================
   // device-type word
   localparam logic [7:0]  MOTOR_BLDC     = 8'h02;
   localparam logic [7:0]  MOTOR_STEPPER  = 8'h04;
   localparam logic [7:0]  MOTOR_BOTH     = 8'h06;
   localparam logic [15:0] PROFILE_NUM    = 16'h0192;

   // ==========================================================================
   // error summary bits
   localparam int          SUM_ANY        = 0;
   localparam int          SUM_AMP        = 1;
   localparam int          SUM_SUPPLY     = 2;
   localparam int          SUM_TEMP       = 3;
   localparam int          SUM_LINK       = 4;
   localparam int          SUM_PROFILE    = 5;
   localparam int          SUM_ZERO       = 6;
   localparam int          SUM_VEND       = 7;
   localparam logic [7:0]  SUM_RESET      = 8'h00;

   // ==========================================================================
   // error history
   localparam int          HIST_DEPTH     = 8;
   localparam logic [3:0]  HIST_FULL      = 4'h8;
   localparam logic [31:0] ABORT_NO_DATA  = 32'h08000024;
   localparam int          ENT_NUM_LSB    = 24;
   localparam int          ENT_CLASS_LSB  = 16;

   // ==========================================================================
   // interrupt status bits
   localparam int          IRQ_W          = 3;
   localparam int          IRQ_LOGGED     = 0;
   localparam int          IRQ_SUM_RISE   = 1;
   localparam int          IRQ_DISCARD    = 2;
endpackage
`default_nettype wire

// ===== logic/dio_ident_errors.sv
// dio_ident_errors: device-type word, error summary and error history stack.
// assumes: fault levels and error records come from logic on aclk; AXI4-Lite master
// keeps one write and one read under way at most.
//
// Register access over AXI4-Lite was decided locally.
`default_nettype none

module dio_ident_errors
   import dio_pkg::*;
#(
   parameter logic [7:0] MOTOR_SUPPORT = MOTOR_BOTH
)
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // fault levels, one per summary bit (bit 6 ignored)
   input  wire logic [7:0]        fault_cond,
   // error record strobe and fields
   input  wire logic              err_push,
   input  wire logic [7:0]        err_number,
   input  wire logic [7:0]        err_class,
   input  wire logic [15:0]       err_code,
   // interrupt
   output logic                   irq
);

   // ==========================================================================
   // state
   logic [7:0]        sum_r;
   logic [3:0]        count_r;
   logic [31:0]       hist_r [HIST_DEPTH];
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_en_r;
   logic              aw_have_r;
   logic              w_have_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [3:0]        wstrb_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              rvalid_r;
   logic [1:0]        rresp_r;
   logic [DATA_W-1:0] rdata_r;

   // ==========================================================================
   // device-type word and summary next value
   wire [31:0] dev_type_word = {8'h00, MOTOR_SUPPORT, PROFILE_NUM};
   wire [31:0] new_entry     = {err_number, err_class, err_code};
   wire [7:0]  sum_nxt;
   // summary follows the fault levels; bit 6 reads zero, general bit reports any fault but bit 6
   wire [7:0]  fault_seen;
   genvar gs;
   for (gs = 0; gs < 8; gs++)
   begin : g_sum
      assign fault_seen[gs] = (gs == SUM_ZERO) ? 1'b0 : fault_cond[gs];
   end
   assign sum_nxt = {fault_seen[7:1], |fault_seen};

   // ==========================================================================
   // write channel decode
   wire wr_go      = aw_have_r & w_have_r & ~bvalid_r;
   wire wa_dev     = awaddr_r == ADDR_DEV_TYPE;
   wire wa_sum     = awaddr_r == ADDR_ERR_SUM;
   wire wa_cnt     = (awaddr_r == ADDR_ERR_HIST) | (awaddr_r == HIST_SUB_BASE);
   wire wa_ent     = (awaddr_r > HIST_SUB_BASE) &
                     (awaddr_r <= HIST_SUB_BASE + ADDR_W'(4 * HIST_DEPTH)) &
                     (awaddr_r[1:0] == 2'h0);
   wire wa_istat   = awaddr_r == ADDR_IRQ_STAT;
   wire wa_iclr    = awaddr_r == ADDR_IRQ_CLR;
   wire wa_ien     = awaddr_r == ADDR_IRQ_EN;
   wire cnt_zero_w = wstrb_r[0] & (wdata_r[7:0] == 8'h00);
   wire clr_hist   = wr_go & wa_cnt & cnt_zero_w;
   wire irq_clr_go = wr_go & wa_iclr & wstrb_r[0];
   wire irq_en_go  = wr_go & wa_ien & wstrb_r[0];
   wire [1:0] bresp_nxt = (wa_dev | wa_sum | wa_ent | wa_istat) ? RESP_SLVERR :
                          wa_cnt  ? (cnt_zero_w ? RESP_OKAY : RESP_SLVERR) :
                          (wa_iclr | wa_ien) ? RESP_OKAY : RESP_DECERR;

   // ==========================================================================
   // read channel decode
   wire        rd_go     = s_axi_arvalid & ~rvalid_r;
   wire [ADDR_W-1:0] ra  = s_axi_araddr;
   wire [ADDR_W-1:0] ra_off = ADDR_W'(ra - HIST_SUB_BASE);
   wire        ra_sub    = (ra >= HIST_SUB_BASE) & (ra_off[1:0] == 2'h0) &
                           (ra_off <= ADDR_W'(4 * HIST_DEPTH));
   wire [3:0]  ra_k      = ra_off[5:2];
   wire        ra_cnt    = (ra == ADDR_ERR_HIST) | (ra_sub & (ra_k == 4'h0));
   wire        ra_ent    = ra_sub & (ra_k != 4'h0);
   wire        ra_empty  = ra_ent & (count_r == 4'h0);
   wire [2:0]  ra_slot   = 3'(ra_k - 4'h1);
   wire [31:0] rdata_nxt = (ra == ADDR_DEV_TYPE) ? dev_type_word :
                           (ra == ADDR_ERR_SUM)  ? {24'h000000, sum_r} :
                           ra_cnt   ? {28'h0000000, count_r} :
                           ra_empty ? ABORT_NO_DATA :
                           ra_ent   ? hist_r[ra_slot] :
                           (ra == ADDR_IRQ_STAT) ? {29'h0, irq_stat_r} :
                           (ra == ADDR_IRQ_EN)   ? {29'h0, irq_en_r} : 32'h00000000;
   wire        ra_known  = (ra == ADDR_DEV_TYPE) | (ra == ADDR_ERR_SUM) | ra_cnt | ra_ent |
                           (ra == ADDR_IRQ_STAT) | (ra == ADDR_IRQ_EN) | (ra == ADDR_IRQ_CLR);
   wire [1:0]  rresp_nxt = ra_empty ? RESP_SLVERR : (ra_known ? RESP_OKAY : RESP_DECERR);

   // ==========================================================================
   // bus outputs
   assign s_axi_awready = ~aw_have_r;
   assign s_axi_wready  = ~w_have_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   // write address and data capture, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= 16'h0000;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_have_r)
         begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_have_r <= 1'b0;
         if (s_axi_wvalid && !w_have_r)
         begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         else if (wr_go)
            w_have_r <= 1'b0;
      end
   end
   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= bresp_nxt;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end
   // read response, one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= 32'h00000000;
      end
      else if (rd_go)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= rresp_nxt;
         rdata_r  <= rdata_nxt;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end
   // ==========================================================================
   // summary register: follows faults, host writes never reach it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sum_r <= SUM_RESET;
      else
         sum_r <= sum_nxt;
   end

   // ==========================================================================
   // history stack: a push after a clear in the same cycle still lands
   wire [3:0] count_base = clr_hist ? 4'h0 : count_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_r <= 4'h0;
      else if (err_push)
         count_r <= (count_base == HIST_FULL) ? HIST_FULL : 4'(count_base + 4'h1);
      else if (clr_hist)
         count_r <= 4'h0;
   end
   // one flop word per entry; entry 0 is position 1
   genvar gi;
   for (gi = 0; gi < HIST_DEPTH; gi++)
   begin : g_hist
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            hist_r[gi] <= 32'h00000000;
         else if (err_push)
            hist_r[gi] <= (gi == 0) ? new_entry : hist_r[(gi == 0) ? 0 : gi - 1];
         else if (clr_hist)
            hist_r[gi] <= 32'h00000000;
      end
   end

   // ==========================================================================
   // interrupts: set wins over a clear in the same cycle
   wire [IRQ_W-1:0] irq_ev;
   assign irq_ev[IRQ_LOGGED]   = err_push;
   assign irq_ev[IRQ_SUM_RISE] = |(sum_nxt & ~sum_r);
   assign irq_ev[IRQ_DISCARD]  = err_push & (count_base == HIST_FULL);
   wire [IRQ_W-1:0] irq_clr_m  = irq_clr_go ? wdata_r[IRQ_W-1:0] : '0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_r <= '0;
         irq_en_r   <= '0;
      end
      else
      begin
         irq_stat_r <= (irq_stat_r & ~irq_clr_m) | irq_ev;
         if (irq_en_go)
            irq_en_r <= wdata_r[IRQ_W-1:0];
      end
   end
   assign irq = |(irq_stat_r & irq_en_r);
   // ==========================================================================
   // checks, all on aclk and idle while reset is held
   default clocking cb_chk @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire rd_take = s_axi_arvalid & s_axi_arready;
   sequence s_rd_taken(logic [ADDR_W-1:0] a);
      rd_take && (s_axi_araddr == a);
   endsequence
   property p_dev_type_fixed;
      s_rd_taken(ADDR_DEV_TYPE) |=> s_axi_rvalid && (s_axi_rdata == dev_type_word)
                                   && (s_axi_rresp == RESP_OKAY);
   endproperty
   a_dev_type_fixed: assert property (p_dev_type_fixed)
      else $error("device-type read wrong");
   property p_profile_field;
      s_rd_taken(ADDR_DEV_TYPE) |=> s_axi_rdata[15:0] == 16'h0192;
   endproperty
   a_profile_field: assert property (p_profile_field)
      else $error("profile number wrong");
   property p_motor_field;
      s_rd_taken(ADDR_DEV_TYPE) |=> (s_axi_rdata[23:16] == MOTOR_SUPPORT)
                                   && (s_axi_rdata[31:24] == 8'h00);
   endproperty
   a_motor_field: assert property (p_motor_field)
      else $error("motor type field wrong");
   property p_sum_reset;
      $rose(aresetn) |-> (sum_r == 8'h00) && (count_r == 4'h0);
   endproperty
   a_sum_reset: assert property (p_sum_reset)
      else $error("summary not zero after reset");
   // bits 7..1 one cycle behind their fault levels, bit 0 the OR of all levels but bit 6, bit 6 always low
   property p_sum_track;
      ##1 (sum_r[7:1] == ($past(fault_cond[7:1]) & 7'h5f))
          && (sum_r[SUM_ANY] == |$past(fault_cond & 8'hbf));
   endproperty
   a_sum_track: assert property (p_sum_track)
      else $error("summary does not follow faults");
   property p_push_stack;
      err_push && !clr_hist |=> (hist_r[0] == $past(new_entry))
                               && (hist_r[1] == $past(hist_r[0]))
                               && (count_r == ((($past(count_r)) == 4'h8) ? 4'h8
                                               : 4'($past(count_r) + 4'h1)));
   endproperty
   a_push_stack: assert property (p_push_stack)
      else $error("history push wrong");
   property p_count_bound;
      count_r <= 4'h8;
   endproperty
   a_count_bound: assert property (p_count_bound)
      else $error("history count over eight");
   // the response of the clearing write stands in the cycle after the clear
   property p_clear_hist;
      clr_hist && !err_push |=> (count_r == 4'h0) && s_axi_bvalid && (s_axi_bresp == RESP_OKAY);
   endproperty
   a_clear_hist: assert property (p_clear_hist)
      else $error("history clear wrong");
   property p_empty_abort;
      rd_take && ra_ent && (count_r == 4'h0) |=> s_axi_rvalid
         && (s_axi_rresp == RESP_SLVERR) && (s_axi_rdata == 32'h08000024);
   endproperty
   a_empty_abort: assert property (p_empty_abort)
      else $error("empty history read not refused");
   property p_ro_write;
      wr_go && (wa_dev || wa_sum) |=> s_axi_bvalid && (s_axi_bresp == RESP_SLVERR);
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("read-only write not refused");
endmodule
`default_nettype wire

// ===== dv/dio_host_model.sv
// dio_host_model: axi4-lite master standing in for the fieldbus host.
// assumes: shares aclk with the register bank; callers run one access at a time.
`default_nettype none
module dio_host_model
   import dio_pkg::*;
(
   // clock
   input  wire logic              aclk,
   // write address, data and response
   output var logic [ADDR_W-1:0]  awaddr,
   output var logic               awvalid,
   input  wire logic              awready,
   output var logic [DATA_W-1:0]  wdata,
   output var logic [3:0]         wstrb,
   output var logic               wvalid,
   input  wire logic              wready,
   input  wire logic [1:0]        bresp,
   input  wire logic              bvalid,
   output var logic               bready,
   // read address and data
   output var logic [ADDR_W-1:0]  araddr,
   output var logic               arvalid,
   input  wire logic              arready,
   input  wire logic [DATA_W-1:0] rdata,
   input  wire logic [1:0]        rresp,
   input  wire logic              rvalid,
   output var logic               rready,
   // raised when an answer never came
   output var logic               hung
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================================
   // idle values at time zero
   initial
   begin
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
      rready = 1'b0;
      hung = 1'b0;
   end

   // ==========================================================================
   // one write; ready and response are sampled at the negedge before the taking edge
   task automatic bus_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ta, tw, tr;
      r = 2'hx;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tr = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta)
         begin
            awvalid <= 1'b0;
            awaddr <= ~a;    // released address no longer shows the old value
         end
         if (tw)
         begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (tr)
         begin
            bready <= 1'b0;
            break;
         end
      end
      if (n == 64)
         hung = 1'b1;    // seen at once, even by a verdict in this time step
   endtask

   // ==========================================================================
   // one read; data and response are sampled at the negedge before the edge that rready meets rvalid
   task automatic bus_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ta, tr;
      d = 32'hx;
      r = 2'hx;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta)
         begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (tr)
         begin
            rready <= 1'b0;
            break;
         end
      end
      if (n == 64)
         hung = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== dv/test_dio_ident_errors.sv
// test_dio_ident_errors: self-checking bench of the identification and error bank.
// assumes: dio_host_model plays the host on the register bus; one 40 MHz clock.
`default_nettype none
module test_dio_ident_errors
   import dio_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================================
   // signals
   localparam logic [7:0] MOTOR_SEL = MOTOR_STEPPER;
   logic              aclk, aresetn, hung, irq, err_push;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [7:0]        fault_cond, err_number, err_class;
   logic [15:0]       err_code;
   int                fails;
   int                samples_checked;

   // clock of 25 ns
   always #12.5 aclk = ~aclk;

   dio_ident_errors #(.MOTOR_SUPPORT(MOTOR_SEL)) DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .fault_cond(fault_cond), .err_push(err_push),
      .err_number(err_number), .err_class(err_class), .err_code(err_code), .irq(irq));

   dio_host_model host (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung));

   // ==========================================================================
   // compares, one per kind of result
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic irq_is(input logic exp);
      @(negedge aclk);
      samples_checked++;
      if (irq !== exp)
      begin
         fails++;
         $display("unexpected at %0t: irq %b, wanted %b", $time, irq, exp);
      end
   endtask

   // ==========================================================================
   // bus helpers, expectations and record pushes
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
      logic [31:0] gd;
      logic [1:0]  gr;
      host.bus_read(a, gd, gr);
      chk_word(gd, d);
      chk_resp(gr, r);
   endtask

   task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
      logic [1:0] gr;
      host.bus_write(a, d, gr);
      chk_resp(gr, r);
   endtask

   // general bit follows any fault but bit 6, bit 6 never reads 1
   function automatic logic [31:0] sum_exp(input logic [7:0] f);
      logic [7:0] e;
      e = f & 8'hbf;
      e[0] = |e;
      return {24'h0, e};
   endfunction

   function automatic logic [31:0] rec(input int j);
      return {8'(j), 8'ha0 + 8'(j), 16'hc000 + 16'(j)};
   endfunction

   // back-to-back records, one per cycle
   task automatic push_run(input int first, input int n);
      int j;
      for (j = first; j < first + n; j++)
      begin
         @(posedge aclk);
         err_push <= 1'b1;
         {err_number, err_class, err_code} <= rec(j);
      end
      @(posedge aclk);
      err_push <= 1'b0;
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0 && hung !== 1'b1)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================================
   // scenarios
   task automatic sc_reset();
      rd_chk(ADDR_DEV_TYPE, {8'h00, MOTOR_SEL, PROFILE_NUM}, RESP_OKAY);
      rd_chk(ADDR_ERR_SUM, 32'h0, RESP_OKAY);
      rd_chk(ADDR_ERR_HIST, 32'h0, RESP_OKAY);
      rd_chk(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
      rd_chk(ADDR_IRQ_CLR, 32'h0, RESP_OKAY);
      rd_chk(16'h0010, 32'h0, RESP_DECERR);
      wr_chk(16'h0010, 32'h1, RESP_DECERR);
      wr_chk(ADDR_DEV_TYPE, 32'hffffffff, RESP_SLVERR);
      rd_chk(ADDR_DEV_TYPE, {8'h00, MOTOR_SEL, PROFILE_NUM}, RESP_OKAY);
   endtask

   task automatic sc_faults();
      int i;
      for (i = 0; i < 9; i++)
      begin
         @(posedge aclk);
         fault_cond <= (i == 8) ? 8'hff : 8'h01 << i;
         rd_chk(ADDR_ERR_SUM, sum_exp((i == 8) ? 8'hff : 8'h01 << i), RESP_OKAY);
      end
      wr_chk(ADDR_ERR_SUM, 32'h0, RESP_SLVERR);
      rd_chk(ADDR_ERR_SUM, 32'hbf, RESP_OKAY);
      @(posedge aclk);
      fault_cond <= 8'h00;
      rd_chk(ADDR_ERR_SUM, 32'h0, RESP_OKAY);
   endtask

   task automatic sc_history();
      int j;
      rd_chk(HIST_SUB_BASE + 16'h4, ABORT_NO_DATA, RESP_SLVERR);
      rd_chk(HIST_SUB_BASE + 16'h20, ABORT_NO_DATA, RESP_SLVERR);
      wr_chk(ADDR_IRQ_CLR, 32'h7, RESP_OKAY);
      push_run(1, 9);
      rd_chk(ADDR_ERR_HIST, 32'h8, RESP_OKAY);
      for (j = 1; j < 9; j++)
         rd_chk(HIST_SUB_BASE + 16'(4 * j), rec(10 - j), RESP_OKAY);
      rd_chk(ADDR_IRQ_STAT, 32'h5, RESP_OKAY);
      wr_chk(HIST_SUB_BASE + 16'h4, 32'h0, RESP_SLVERR);
      wr_chk(ADDR_ERR_HIST, 32'h3, RESP_SLVERR);
      rd_chk(HIST_SUB_BASE, 32'h8, RESP_OKAY);
      wr_chk(HIST_SUB_BASE, 32'h0, RESP_OKAY);
      rd_chk(ADDR_ERR_HIST, 32'h0, RESP_OKAY);
      rd_chk(HIST_SUB_BASE + 16'h4, ABORT_NO_DATA, RESP_SLVERR);
   endtask

   task automatic sc_irq();
      wr_chk(ADDR_IRQ_CLR, 32'h7, RESP_OKAY);
      push_run(11, 1);
      rd_chk(ADDR_ERR_HIST, 32'h1, RESP_OKAY);
      rd_chk(HIST_SUB_BASE + 16'h4, rec(11), RESP_OKAY);
      rd_chk(HIST_SUB_BASE + 16'h8, 32'h0, RESP_OKAY);
      rd_chk(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
      irq_is(1'b0);
      wr_chk(ADDR_IRQ_EN, 32'h3, RESP_OKAY);
      rd_chk(ADDR_IRQ_EN, 32'h3, RESP_OKAY);
      irq_is(1'b1);
      wr_chk(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
      irq_is(1'b0);
      @(posedge aclk);
      fault_cond <= 8'h08;
      rd_chk(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
      irq_is(1'b1);
      wr_chk(ADDR_IRQ_STAT, 32'h0, RESP_SLVERR);
      wr_chk(ADDR_IRQ_CLR, 32'h2, RESP_OKAY);
      irq_is(1'b0);
      rd_chk(ADDR_ERR_SUM, 32'h9, RESP_OKAY);
   endtask

   // ==========================================================================
   // a host access that never finished ends the run
   always @(posedge aclk)
   begin
      if (hung === 1'b1)
      begin
         fails++;
         end_sim();
      end
   end

   // main sequence
   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      fault_cond = 8'h00;
      err_push = 1'b0;
      err_number = 8'h00;
      err_class = 8'h00;
      err_code = 16'h0000;
      fails = 0;
      samples_checked = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      sc_reset();
      sc_faults();
      sc_history();
      sc_irq();
      end_sim();
   end
endmodule
`default_nettype wire
